// >>> hw/wsw_watchdog.sv
// Watchdog timer with sleep entry, wake-up and status flag handling.
//
// Operation
// [R1] Watchdog counts only ticks of the slow internal oscillator.
// [R2] Mode 11: watchdog always runs, also in sleep.
// [R3] Mode 10: watchdog runs awake, is off in sleep.
// [R4] Mode 01: software enable bit turns the watchdog on or off.
// [R5] Modes 00 and 1x ignore the enable bit; 00 is always off.
// [R6] Awake expiry without a clear resets the device.
// [R7] Period code doubles 1:32 per step to 10010; higher codes give 1:32.
// [R8] Every reset loads period code 01011 (1:65536).
// [R9] Count clears on reset, clear, sleep, wake, osc fail, off, start-up.
// [R10] Changing the fast oscillator divider leaves the count alone.
// [R11] Crystal clocks hold the count clear for 1024 start-up periods.
// [R12] Expiry in sleep wakes the device and updates the flags.
// [R13] Reset pin, brown-out, power-on reset; interrupts and expiry resume.
// [R14] Sleep execution prefetches the next instruction.
// [R15] Enabled interrupts wake; with global enable, vector after one more.
// [R16] Pending enabled interrupt makes sleep a no-op, flags untouched.
// [R17] Interrupt during sleep entry still sleeps, then wakes at once.
// [R18] Every wake-up clears the watchdog.
// [R19] Sleep entry stops the CPU clock, clears PD, sets TO.
// [R20] A watchdog expiry drives the time-out flag low.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module wsw_watchdog
    import wsw_pkg::*;
#(
    parameter int MIN_SHIFT   = WSW_MIN_SHIFT,
    parameter int OST_PERIODS = WSW_OST_PERIODS
)
(
    // Clock and reset.
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    // Register port.
    input  wire wsw_bus_t     bus_i,
    output logic [7:0]        rdata_o,
    // Configuration and asynchronous pins.
    input  wire logic [1:0]   watchdog_mode_config_i,
    input  wire logic         low_freq_internal_osc_i,
    input  wire logic         crystal_osc_i,
    input  wire wsw_rst_src_t rst_src_i,
    // Core events, same clock domain.
    input  wire logic         watchdog_clear_instruction_i,
    input  wire logic         sleep_exec_i,
    input  wire logic         irq_pending_i,
    input  wire logic         global_irq_enable_i,
    input  wire logic         instr_retire_i,
    input  wire logic         osc_fail_i,
    input  wire logic         crystal_clk_sel_i,
    // Results.
    output logic              device_reset_o,
    output logic              cpu_clk_en_o,
    output logic              wake_o,
    output logic              prefetch_o,
    output logic              irq_vector_o,
    output logic              sleeping_o,
    output logic              timeout_flag_n_o,
    output logic              powerdown_flag_n_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic                 lf_s1;
        logic                 lf_s2;
        logic                 lf_s3;
        logic                 xt_s1;
        logic                 xt_s2;
        logic                 xt_s3;
        wsw_rst_src_t         rs_s1;
        wsw_rst_src_t         rs_s2;
        wsw_pwr_t             pwr;
        logic [WSW_CNT_W-1:0] cnt;
        logic [WSW_OST_W-1:0] osc_startup_timer;
        logic [4:0]           ps;
        logic                 swen;
        logic                 to_n;
        logic                 pd_n;
        logic                 cpu_clk_en;
        logic                 dev_reset;
        logic                 wake;
        logic                 prefetch;
        logic                 vec_pend;
        logic                 vector;
        logic [7:0]           rdata;
        logic                 sleeping;
    } wsw_state_t;

    wsw_state_t           s_q;
    wsw_state_t           s_d;
    logic                 lf_tick;
    logic                 xt_tick;
    logic                 running;
    logic                 expire;
    logic                 clear;
    logic                 entry;
    logic                 any_rst;
    logic [WSW_CNT_W-1:0] term;
    logic [4:0]           shift;

    // Edge of each synchronised oscillator; the first stage feeds only the second.
    assign lf_tick = s_q.lf_s2 & ~s_q.lf_s3;  // [R1]
    assign xt_tick = s_q.xt_s2 & ~s_q.xt_s3;
    assign any_rst = |s_q.rs_s2;
    assign entry   = sleep_exec_i & (s_q.pwr == WSW_PWR_AWAKE)
                   & ~irq_pending_i & ~any_rst;

    // Reserved codes fall back to the shortest period.
    always_comb
    begin
        if (s_q.ps > WSW_PS_MAX)  // [R7]
            shift = 5'(MIN_SHIFT);
        else
            shift = 5'(MIN_SHIFT) + s_q.ps;
        term = (WSW_CNT_W'(1) << shift) - WSW_CNT_W'(1);
    end

    // Mode table; the enable bit matters only in software mode.
    always_comb
    begin
        case (watchdog_mode_config_i)
            WSW_MODE_ON:     running = 1'b1;  // [R2]
            WSW_MODE_NSLEEP: running = (s_q.pwr != WSW_PWR_SLEEP);  // [R3]
            WSW_MODE_SW:     running = s_q.swen;  // [R4]
            default:         running = 1'b0;  // [R5]
        endcase
    end

    assign expire = running & lf_tick & (s_q.cnt == term);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_d           = s_q;
        s_d.dev_reset = 1'b0;
        s_d.wake      = 1'b0;
        s_d.prefetch  = 1'b0;
        s_d.vector    = 1'b0;
        clear         = osc_fail_i | ~running;  // [R9]
        s_d.lf_s1     = low_freq_internal_osc_i;
        s_d.lf_s2     = s_q.lf_s1;
        s_d.lf_s3     = s_q.lf_s2;
        s_d.xt_s1     = crystal_osc_i;
        s_d.xt_s2     = s_q.xt_s1;
        s_d.xt_s3     = s_q.xt_s2;
        s_d.rs_s1     = rst_src_i;
        s_d.rs_s2     = s_q.rs_s1;

        // Control register write; only period and enable are stored.
        if (bus_i.wr && bus_i.addr == WSW_CTRL_ADDR)
        begin
            s_d.ps   = bus_i.wdata[WSW_PS_LSB +: 5];
            s_d.swen = bus_i.wdata[WSW_SWEN_BIT];
        end

        case (s_q.pwr)
            WSW_PWR_AWAKE:
            begin
                if (watchdog_clear_instruction_i)
                begin
                    clear    = 1'b1;  // [R9]
                    s_d.to_n = 1'b1;
                    s_d.pd_n = 1'b1;
                end
                // A pending interrupt holds entry low, so sleep is a no-op
                // and an expiry in that cycle still resets.  [R16]
                if (entry)
                begin
                    s_d.pwr        = WSW_PWR_SLEEP;
                    s_d.cpu_clk_en = 1'b0;  // [R19]
                    s_d.pd_n       = 1'b0;  // [R19]
                    s_d.to_n       = 1'b1;  // [R19]
                    s_d.prefetch   = 1'b1;  // [R14]
                    clear          = 1'b1;  // [R9]
                end
                else if (expire)
                begin
                    s_d.dev_reset = 1'b1;  // [R6]
                    s_d.to_n      = 1'b0;  // [R20]
                    s_d.pd_n      = 1'b1;
                    s_d.ps        = WSW_PS_RESET;  // [R8]
                    s_d.swen      = WSW_SWEN_RESET;
                    clear         = 1'b1;
                end
                // Vector one instruction after an interrupt wake-up.
                if (s_q.vec_pend && instr_retire_i)
                begin
                    s_d.vector   = 1'b1;  // [R15]
                    s_d.vec_pend = 1'b0;
                end
            end
            WSW_PWR_SLEEP:
            begin
                // A late interrupt lands here: sleep done, wake now.  [R17]
                if (irq_pending_i || expire)  // [R13]
                begin
                    clear        = 1'b1;  // [R18]
                    s_d.vec_pend = irq_pending_i
                                 & global_irq_enable_i;  // [R15]
                    if (expire)
                        s_d.to_n = 1'b0;  // [R12] [R20]
                    if (crystal_clk_sel_i)
                    begin
                        s_d.pwr = WSW_PWR_OST;  // [R11]
                        s_d.osc_startup_timer = '0;
                    end
                    else
                    begin
                        s_d.pwr        = WSW_PWR_AWAKE;
                        s_d.cpu_clk_en = 1'b1;
                        s_d.wake       = 1'b1;  // [R12]
                    end
                end
            end
            WSW_PWR_OST:
            begin
                // Held clear for the whole crystal start-up.
                clear = 1'b1;  // [R11]
                if (xt_tick)
                begin
                    s_d.osc_startup_timer = s_q.osc_startup_timer + WSW_OST_W'(1);
                    if (s_q.osc_startup_timer == WSW_OST_W'(OST_PERIODS - 1))
                    begin
                        s_d.pwr        = WSW_PWR_AWAKE;
                        s_d.cpu_clk_en = 1'b1;
                        s_d.wake       = 1'b1;
                    end
                end
            end
            default:
            begin
                s_d.pwr        = WSW_PWR_AWAKE;
                s_d.cpu_clk_en = 1'b1;
            end
        endcase

        // Reset sources win over everything and wake a sleeping device.
        if (any_rst)
        begin
            s_d.pwr        = WSW_PWR_AWAKE;  // [R13]
            s_d.cpu_clk_en = 1'b1;
            s_d.dev_reset  = 1'b1;
            s_d.wake       = 1'b0;
            s_d.vec_pend   = 1'b0;
            s_d.ps         = WSW_PS_RESET;  // [R8]
            s_d.swen       = WSW_SWEN_RESET;
            clear          = 1'b1;  // [R9]
            if (s_q.rs_s2.power_on)
            begin
                s_d.to_n = WSW_FLAG_RESET;
                s_d.pd_n = WSW_FLAG_RESET;
            end
        end

        // Counter; the fast oscillator divider is not an input here,
        // so changing it cannot disturb the count.  [R10]
        if (clear)
            s_d.cnt = '0;
        else if (lf_tick)
            s_d.cnt = expire ? '0 : s_q.cnt + WSW_CNT_W'(1);  // [R1]

        // Registered copy of the sleep state so the pin comes from a flop.
        s_d.sleeping = (s_d.pwr != WSW_PWR_AWAKE) & ~s_d.cpu_clk_en;

        // Read data stands in the cycle after the strobe only.
        s_d.rdata = 8'h00;
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                WSW_CTRL_ADDR: s_d.rdata = {2'b00, s_q.ps, s_q.swen};
                WSW_STAT_ADDR:
                begin
                    s_d.rdata[WSW_STAT_TO_BIT] = s_q.to_n;
                    s_d.rdata[WSW_STAT_PD_BIT] = s_q.pd_n;
                end
                default:       s_d.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_q            <= '0;
            s_q.pwr        <= WSW_PWR_AWAKE;
            s_q.ps         <= WSW_PS_RESET;  // [R8]
            s_q.swen       <= WSW_SWEN_RESET;
            s_q.to_n       <= WSW_FLAG_RESET;
            s_q.pd_n       <= WSW_FLAG_RESET;
            s_q.cpu_clk_en <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign rdata_o            = s_q.rdata;
    assign device_reset_o     = s_q.dev_reset;
    assign cpu_clk_en_o       = s_q.cpu_clk_en;
    assign wake_o             = s_q.wake;
    assign prefetch_o         = s_q.prefetch;
    assign irq_vector_o       = s_q.vector;
    assign sleeping_o         = s_q.sleeping;
    assign timeout_flag_n_o   = s_q.to_n;
    assign powerdown_flag_n_o = s_q.pd_n;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    tick_only_a: assert property (  // [R1]
        (s_q.cnt != $past(s_q.cnt)) && (s_q.cnt != '0) |-> $past(lf_tick))
        else $error("Watchdog advanced without an oscillator tick.");
    off_mode_a: assert property (  // [R5]
        watchdog_mode_config_i == WSW_MODE_OFF |=> s_q.cnt == '0)
        else $error("Watchdog counted in off mode.");
    nsleep_a: assert property (  // [R3]
        watchdog_mode_config_i == WSW_MODE_NSLEEP && s_q.pwr == WSW_PWR_SLEEP
        |-> s_q.cnt == '0)
        else $error("Watchdog counted in sleep in awake-only mode.");
    sw_off_a: assert property (  // [R4]
        watchdog_mode_config_i == WSW_MODE_SW && !s_q.swen |=> s_q.cnt == '0)
        else $error("Watchdog counted with software enable clear.");
    awake_expire_a: assert property (  // [R6]
        expire && s_q.pwr == WSW_PWR_AWAKE && !any_rst && !sleep_exec_i
        |=> device_reset_o && !timeout_flag_n_o)
        else $error("Awake expiry did not reset the device.");
    period_decode_a: assert property (  // [R7]
        s_q.ps > WSW_PS_MAX |-> term == WSW_CNT_W'((1 << MIN_SHIFT) - 1))
        else $error("Reserved period code not decoded as shortest.");
    reset_load_a: assert property (  // [R8]
        device_reset_o |-> s_q.ps == WSW_PS_RESET)
        else $error("Period code not reloaded on reset.");
    clear_instr_a: assert property (  // [R9]
        watchdog_clear_instruction_i && s_q.pwr == WSW_PWR_AWAKE
        |=> s_q.cnt == '0)
        else $error("Clear instruction did not clear the count.");
    ost_hold_a: assert property (  // [R11]
        s_q.pwr == WSW_PWR_OST |=> s_q.cnt == '0)
        else $error("Count moved during start-up wait.");
    sleep_expire_a: assert property (  // [R12]
        expire && s_q.pwr == WSW_PWR_SLEEP && !any_rst
        |=> !device_reset_o && s_q.pwr != WSW_PWR_SLEEP && !timeout_flag_n_o)
        else $error("Sleep expiry handled wrongly.");
    rst_wake_a: assert property (  // [R13]
        $rose(rst_src_i.ext_reset) |-> ##[2:3] device_reset_o)
        else $error("Reset pin did not reset the device.");
    entry_flags_a: assert property (  // [R19]
        entry |=> !cpu_clk_en_o && !powerdown_flag_n_o && timeout_flag_n_o
                  && prefetch_o && s_q.cnt == '0)  // [R14]
        else $error("Sleep entry effects missing.");
    vector_a: assert property (  // [R15]
        irq_vector_o |-> $past(instr_retire_i) && $past(s_q.vec_pend))
        else $error("Vector without a retired instruction.");
    sleep_nop_a: assert property (  // [R16]
        sleep_exec_i && irq_pending_i && s_q.pwr == WSW_PWR_AWAKE
        && !watchdog_clear_instruction_i && !any_rst && !expire
        |=> s_q.pwr == WSW_PWR_AWAKE && $stable(powerdown_flag_n_o)
            && $stable(timeout_flag_n_o))
        else $error("Sleep with pending interrupt was not a no-op.");
    wake_clear_a: assert property (  // [R18]
        s_q.pwr == WSW_PWR_SLEEP ##1 s_q.pwr != WSW_PWR_SLEEP |-> s_q.cnt == '0)
        else $error("Wake-up did not clear the watchdog.");

    sleep_cover_c:  cover property (entry);
    irq_wake_c:     cover property (s_q.pwr == WSW_PWR_SLEEP && irq_pending_i);
    to_wake_c:      cover property (expire && s_q.pwr == WSW_PWR_SLEEP);
    ost_wake_c:     cover property (s_q.pwr == WSW_PWR_OST ##1 wake_o);
    awake_reset_c:  cover property (expire && s_q.pwr == WSW_PWR_AWAKE);

endmodule

// >>> hw/wsw_pkg.sv
// Package of constants and types for the watchdog with sleep and wake logic.
package wsw_pkg;

    // ****************************************************************
    // Register map and field layout
    // ****************************************************************
    localparam logic [3:0] WSW_CTRL_ADDR   = 4'h0;
    localparam logic [3:0] WSW_STAT_ADDR   = 4'h1;
    localparam int         WSW_PS_LSB      = 1;
    localparam int         WSW_SWEN_BIT    = 0;
    localparam int         WSW_STAT_TO_BIT = 4;
    localparam int         WSW_STAT_PD_BIT = 3;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [4:0] WSW_PS_RESET    = 5'h0b;
    localparam logic       WSW_SWEN_RESET  = 1'b0;
    localparam logic       WSW_FLAG_RESET  = 1'b1;

    // ****************************************************************
    // Period decode and mode encodings
    // ****************************************************************
    localparam logic [4:0] WSW_PS_MAX      = 5'h12;
    localparam int         WSW_MIN_SHIFT   = 5;
    localparam int         WSW_CNT_W       = 23;
    localparam logic [1:0] WSW_MODE_OFF    = 2'h0;
    localparam logic [1:0] WSW_MODE_SW     = 2'h1;
    localparam logic [1:0] WSW_MODE_NSLEEP = 2'h2;
    localparam logic [1:0] WSW_MODE_ON     = 2'h3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int         WSW_SYS_CLK_HZ  = 40000000;
    localparam int         WSW_LFOSC_HZ    = 31000;
    localparam int         WSW_OST_PERIODS = 1024;
    localparam int         WSW_OST_W       = 11;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        WSW_PWR_AWAKE,
        WSW_PWR_SLEEP,
        WSW_PWR_OST
    } wsw_pwr_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wsw_bus_t;

    typedef struct packed {
        logic ext_reset;
        logic brownout;
        logic power_on;
    } wsw_rst_src_t;

endpackage

// >>> testbench/wsw_watchdog_tb_top.sv
// Self-checking testbench for the watchdog with sleep and wake logic.
`timescale 1ns/1ps
module wsw_watchdog_tb_top;
    import wsw_pkg::*;

    // ****************************************************************
    // Signals and bench model state
    // ****************************************************************
    logic         clk_sys_i = 1'b0;
    logic         rst_n_i   = 1'b0;
    wsw_bus_t     bus       = '0;
    wsw_rst_src_t src       = '0;
    logic [1:0]   mode      = 2'h0;
    logic         lfo = 1'b0, xtal = 1'b0, clr = 1'b0, slp = 1'b0;
    logic         irq = 1'b0, global_irq_enable = 1'b0, ret = 1'b0, ofail = 1'b0;
    logic         xsel = 1'b0;
    logic [7:0]   rdata;
    logic         dev_rst, cpu_en, wake, pref, vec, to_n, pd_n, sleeping;
    logic [7:0]   rnd       = 8'h26;
    int           n_errors  = 0;
    int           checks    = 0;
    int           n_rst = 0, n_wake = 0, n_pref = 0, n_vec = 0;
    int           m_ps = 11, m_swen = 0, m_to = 1, m_pd = 1;
    int           b, w;

    // Short periods keep each expiry a handful of slow ticks.
    wsw_watchdog #(.MIN_SHIFT(1), .OST_PERIODS(4)) dut_u (
        .clk_sys_i                    (clk_sys_i),
        .rst_n_i                      (rst_n_i),
        .bus_i                        (bus),
        .rdata_o                      (rdata),
        .watchdog_mode_config_i       (mode),
        .low_freq_internal_osc_i      (lfo),
        .crystal_osc_i                (xtal),
        .rst_src_i                    (src),
        .watchdog_clear_instruction_i (clr),
        .sleep_exec_i                 (slp),
        .irq_pending_i                (irq),
        .global_irq_enable_i          (global_irq_enable),
        .instr_retire_i               (ret),
        .osc_fail_i                   (ofail),
        .crystal_clk_sel_i            (xsel),
        .device_reset_o               (dev_rst),
        .cpu_clk_en_o                 (cpu_en),
        .wake_o                       (wake),
        .prefetch_o                   (pref),
        .irq_vector_o                 (vec),
        .sleeping_o                   (sleeping),
        .timeout_flag_n_o             (to_n),
        .powerdown_flag_n_o           (pd_n)
    );

    // ****************************************************************
    // Clock, event counters and helpers
    // ****************************************************************
    // The clock toggles every 12.5 ns, half of its 25 ns period.
    always #12.5 clk_sys_i = ~clk_sys_i;

    // Pulses are counted so that windows can be judged as deltas; the
    // falling edge keeps the count clear of the checks on the rising one.
    always @(negedge clk_sys_i)
    begin
        if (dev_rst === 1'b1) n_rst++;
        if (wake === 1'b1) n_wake++;
        if (pref === 1'b1) n_pref++;
        if (vec === 1'b1) n_vec++;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    function automatic logic [7:0] ctl();
        return {2'b00, 5'(m_ps), 1'(m_swen)};
    endfunction

    function automatic logic [7:0] stat();
        return {3'b000, 1'(m_to), 1'(m_pd), 3'b000};
    endfunction

    // Core-side pins as the model expects them: sleep, flags, clock.
    function automatic logic [7:0] core(input logic c);
        return {4'h0, ~c, 1'(m_to), 1'(m_pd), c};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic end_sim();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_evt(input int got, input int exp);
        checks++;
        if (got != exp)
        begin
            n_errors++;
            $display("Error at %0t: count %h expected %h", $time, got, exp);
        end
    endtask

    // Bus cycles: one-cycle strobes, a spare edge between transfers.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        cyc(1);
        bus.wr <= 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        cyc(1);
        bus.rd <= 1'b0;
        #1 chk_reg(rdata, exp);
        cyc(1);
    endtask

    // Kind 0 is a clear instruction, 1 a sleep, 2 a retired instruction.
    task automatic pulse(input int k);
        case (k)
            0: clr <= 1'b1;
            1: slp <= 1'b1;
            default: ret <= 1'b1;
        endcase
        cyc(1);
        clr <= 1'b0;
        slp <= 1'b0;
        ret <= 1'b0;
        cyc(1);
    endtask

    // Slow edges last several cycles so the synchronisers see each one.
    task automatic tick(input int n, input logic x);
        repeat (n)
        begin
            if (x)
                xtal <= 1'b1;
            else
                lfo <= 1'b1;
            cyc(3);
            xtal <= 1'b0;
            lfo <= 1'b0;
            cyc(3);
        end
    endtask

    // Period zero, count cleared, both flags set.
    task automatic arm();
        wr(WSW_CTRL_ADDR, 8'h00);
        m_ps = 0;
        m_swen = 0;
        pulse(0);
        m_to = 1;
        m_pd = 1;
        b = n_rst;
        w = n_wake;
    endtask

    task automatic wdr();
        m_ps = 11;
        m_swen = 0;
        m_to = 0;
        m_pd = 1;
    endtask

    // Sleep with an interrupt arriving in the first sleeping cycle.
    task automatic nap();
        slp <= 1'b1;
        cyc(1);
        slp <= 1'b0;
        irq <= 1'b1;
        cyc(3);
        irq <= 1'b0;
        m_to = 1;
        m_pd = 0;
        cyc(1);
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial
    begin
        #(25 * 20000);
        n_errors++;
        end_sim();
    end

    initial
    begin
        cyc(8);
        rst_n_i <= 1'b1;
        cyc(2);
        rd(WSW_CTRL_ADDR, ctl());
        rd(WSW_STAT_ADDR, stat());
        rd(4'h7, 8'h00);
        wr(WSW_STAT_ADDR, 8'h00);
        rd(WSW_STAT_ADDR, stat());
        repeat (4)
        begin
            rnd = lfsr(rnd);
            wr(WSW_CTRL_ADDR, rnd);
            m_ps = int'(rnd[5:1]);
            m_swen = int'(rnd[0]);
            rd(WSW_CTRL_ADDR, ctl());
        end
        // Every mode with the enable bit low, awake.
        for (int m = 0; m < 4; m++)
        begin
            mode <= 2'(m);
            arm();
            tick(2, 1'b0);
            cyc(6);
            chk_evt(n_rst - b, int'(m >= 2));
            if (m >= 2)
                wdr();
            rd(WSW_STAT_ADDR, stat());
        end
        // Software mode: a clear restarts the full period.
        mode <= WSW_MODE_SW;
        wr(WSW_CTRL_ADDR, 8'h03);
        m_ps = 1;
        m_swen = 1;
        b = n_rst;
        tick(3, 1'b0);
        pulse(0);
        tick(3, 1'b0);
        cyc(6);
        chk_evt(n_rst - b, 0);
        tick(1, 1'b0);
        cyc(6);
        chk_evt(n_rst - b, 1);
        wdr();
        rd(WSW_CTRL_ADDR, ctl());
        // Reserved period code behaves like the shortest one.
        mode <= WSW_MODE_ON;
        arm();
        wr(WSW_CTRL_ADDR, 8'h26);
        tick(2, 1'b0);
        cyc(6);
        chk_evt(n_rst - b, 1);
        // An oscillator failure clears a half-done count.
        arm();
        tick(1, 1'b0);
        ofail <= 1'b1;
        cyc(2);
        ofail <= 1'b0;
        tick(1, 1'b0);
        cyc(6);
        chk_evt(n_rst - b, 0);
        // Off-in-sleep mode: prefetch, flags, no counting asleep.
        mode <= WSW_MODE_NSLEEP;
        arm();
        w = n_pref;
        pulse(1);
        m_to = 1;
        m_pd = 0;
        chk_evt(n_pref - w, 1);
        chk_reg({4'h0, sleeping, to_n, pd_n, cpu_en}, core(1'b0));
        rd(WSW_STAT_ADDR, stat());
        w = n_wake;
        tick(4, 1'b0);
        chk_evt(n_rst - b + n_wake - w, 0);
        irq <= 1'b1;
        cyc(3);
        irq <= 1'b0;
        cyc(1);
        chk_evt(n_wake - w, 1);
        // Always-on mode: wake clears a partial count.
        mode <= WSW_MODE_ON;
        arm();
        pulse(1);
        tick(1, 1'b0);
        irq <= 1'b1;
        cyc(3);
        irq <= 1'b0;
        tick(1, 1'b0);
        cyc(6);
        chk_evt(n_rst - b, 0);
        // Expiry while asleep wakes without a reset.
        arm();
        pulse(1);
        tick(2, 1'b0);
        cyc(6);
        m_to = 0;
        m_pd = 0;
        chk_evt(n_rst - b + 2 * (n_wake - w), 2);
        rd(WSW_STAT_ADDR, stat());
        // Late interrupt, then pending interrupt turns sleep into a no-op.
        mode <= WSW_MODE_OFF;
        arm();
        nap();
        chk_evt(n_wake - w, 1);
        rd(WSW_STAT_ADDR, stat());
        pulse(0);
        m_to = 1;
        m_pd = 1;
        w = n_pref;
        irq <= 1'b1;
        pulse(1);
        cyc(2);
        irq <= 1'b0;
        chk_evt(n_pref - w, 0);
        chk_reg({4'h0, sleeping, to_n, pd_n, cpu_en}, core(1'b1));
        rd(WSW_STAT_ADDR, stat());
        // Global enable: one more instruction, then the vector.
        global_irq_enable <= 1'b1;
        w = n_vec;
        nap();
        pulse(2);
        cyc(2);
        chk_evt(n_vec - w, 1);
        global_irq_enable <= 1'b0;
        // Crystal clock: stay stopped through the start-up count.
        xsel <= 1'b1;
        nap();
        cyc(4);
        chk_reg({4'h0, sleeping, to_n, pd_n, cpu_en}, core(1'b0));
        tick(4, 1'b1);
        cyc(4);
        chk_reg({4'h0, sleeping, to_n, pd_n, cpu_en}, core(1'b1));
        xsel <= 1'b0;
        // A reset pin pulse resets the device and reloads the period.
        wr(WSW_CTRL_ADDR, 8'h01);
        b = n_rst;
        src.ext_reset <= 1'b1;
        cyc(1);
        src.ext_reset <= 1'b0;
        cyc(6);
        chk_evt(n_rst - b, 1);
        m_ps = 11;
        m_swen = 0;
        rd(WSW_CTRL_ADDR, ctl());
        rd(WSW_STAT_ADDR, stat());
        end_sim();
    end
endmodule
